// *** hw/dsir_pkg.sv ***
// constants and types shared by the status responder blocks
package dsir_pkg;
	// command word layout {data[7:0], address[3:0], code[3:0]}
	localparam int CMD_LSB = 0;
	localparam int ADDR_LSB = 4;
	localparam int DATA_LSB = 8;
	localparam int INIT_PA_LSB = 8;
	localparam int INIT_BANK_LSB = 12;
	localparam int INIT_BS_BIT = 14;
	localparam int INIT_NV_BIT = 15;
	localparam logic [3:0] CMD_INIT = 4'h0;
	localparam logic [3:0] CMD_STATUS = 4'h1;
	localparam logic [3:0] ADDR_GLOBAL = 4'h0;
	// bank combinations accepted by initialization, one bit per code
	localparam logic [3:0] BANK_VALID_MASK = 4'h7;
	// reply lengths and crc widths
	localparam logic [4:0] LONG_LEN = 5'h10;
	localparam logic [4:0] SHORT_LEN = 5'h0F;
	localparam logic [4:0] SHORT_MIN = 5'h08;
	localparam logic [3:0] INIT_CRC_W = 4'h4;
	localparam logic [3:0] CRC_W_MAX = 4'h8;
	localparam logic [7:0] CRC4_POLY = 8'h03;
	localparam logic [7:0] CRC4_SEED = 8'h0A;
	localparam logic [7:0] CRC_GEN_POLY = 8'h07;
	localparam logic [7:0] CRC_GEN_SEED = 8'h00;
	// reply field positions
	localparam int RPL_ADDR_HI_LSB = 12;
	localparam int RPL_BF_BIT = 8;
	// register offsets
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_PREADDR = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_EVENT = 3'h3;
	// register fields and reset values
	localparam int CTRL_AT_LSB = 0;
	localparam int CTRL_ENH_LONG_BIT = 2;
	localparam int CTRL_ENH_SHORT_BIT = 3;
	localparam int CTRL_CRC_LSB = 4;
	localparam int PRE_FLAG_BIT = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PREADDR_RESET = 8'h00;
	localparam logic [2:0] EVENT_RESET = 3'h0;
	typedef enum logic [1:0] {DSIR_IDLE, DSIR_CRC} dsir_state_t;
endpackage : dsir_pkg

// *** hw/dsir_reply_if.sv ***
// reply word handed from the responder to the crc generator
`timescale 1ns/1ns
`default_nettype none
interface dsir_reply_if;
	logic start;
	logic [15:0] word;
	logic [4:0] len;
	logic [3:0] crc_w;
	logic [7:0] crc;
	logic done;
	modport ctrl_side (output start, output word, output len, output crc_w,
		input crc, input done);
	modport crc_side (input start, input word, input len, input crc_w,
		output crc, output done);
endinterface : dsir_reply_if
`default_nettype wire

// *** hw/dsir_crc_gen.sv ***
// serial crc over the reply bits, msb first, one bit per clock
`timescale 1ns/1ns
`default_nettype none
module dsir_crc_gen import dsir_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	dsir_reply_if.crc_side rif
);
	logic [7:0] crc_reg;
	logic [4:0] idx_reg;
	logic run_reg;
	logic done_reg;
	// width mask and top bit of the selected crc width
	wire logic [7:0] wmask = 8'((9'h001 << rif.crc_w) - 9'h001);
	wire logic [7:0] topsel = wmask ^ (wmask >> 1);
	wire logic is_crc4 = (rif.crc_w == INIT_CRC_W);
	wire logic [7:0] poly = (is_crc4 ? CRC4_POLY : CRC_GEN_POLY) & wmask;
	wire logic [7:0] seed = (is_crc4 ? CRC4_SEED : CRC_GEN_SEED) & wmask;
	wire logic fb = rif.word[idx_reg[3:0]] ^ (|(crc_reg & topsel));
	wire logic [7:0] crc_step = ((crc_reg << 1) ^ (fb ? poly : 8'h00)) & wmask;

	// word stays stable in the caller while running, so no local copy
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			crc_reg <= 8'h00;
			idx_reg <= 5'h00;
			run_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (i_clk_en) begin
			done_reg <= run_reg && (idx_reg == 5'h00);
			if (rif.start) begin
				crc_reg <= seed;
				idx_reg <= rif.len - 5'h01;
				run_reg <= 1'b1;
			end else if (run_reg) begin
				crc_reg <= crc_step;
				idx_reg <= idx_reg - 5'h01;
				run_reg <= (idx_reg != 5'h00);
			end
		end
	end

	assign rif.crc = crc_reg;
	assign rif.done = done_reg;
endmodule : dsir_crc_gen
`default_nettype wire

// *** hw/dsir_regs.sv ***
// software register file: control, preset address, status and events
`timescale 1ns/1ns
`default_nettype none
module dsir_regs import dsir_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	input wire logic [2:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_status,
	input wire logic [2:0] i_event_set,
	output logic [7:0] o_reg_rdata,
	output logic [7:0] o_ctrl,
	output logic [7:0] o_preaddr
);
	logic [7:0] ctrl_reg;
	logic [7:0] preaddr_reg;
	logic [2:0] event_reg;
	logic [7:0] rdata_reg;
	wire logic wr_ctrl = i_reg_wr && (i_reg_addr == REG_CTRL);
	wire logic wr_pre = i_reg_wr && (i_reg_addr == REG_PREADDR);
	wire logic wr_event = i_reg_wr && (i_reg_addr == REG_EVENT);
	wire logic [2:0] event_clr = wr_event ? i_reg_wdata[2:0] : 3'h0;
	// read mux, unmapped offsets read as zero
	wire logic [7:0] rd_mux =
		(i_reg_addr == REG_CTRL) ? ctrl_reg :
		(i_reg_addr == REG_PREADDR) ? preaddr_reg :
		(i_reg_addr == REG_STATUS) ? i_status :
		(i_reg_addr == REG_EVENT) ? {5'h00, event_reg} : 8'h00;

	// events are write-one-to-clear; a set in the same cycle wins
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_reg <= CTRL_RESET;
			preaddr_reg <= PREADDR_RESET;
			event_reg <= EVENT_RESET;
			rdata_reg <= 8'h00;
		end else if (i_clk_en) begin
			if (wr_ctrl) ctrl_reg <= i_reg_wdata;
			if (wr_pre) preaddr_reg <= i_reg_wdata;
			event_reg <= (event_reg & ~event_clr) | i_event_set;
			if (i_reg_rd) rdata_reg <= rd_mux;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_ctrl = ctrl_reg;
	assign o_preaddr = preaddr_reg;
endmodule : dsir_regs
`default_nettype wire

// *** hw/dsir_responder.sv ***
// initialization and status-request command handling of a bus satellite
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - once initialized, further initialization commands are ignored without reply
// - init reply: address at 15..12 and 3..0, bus fault, otp, switch, bank, 4-bit crc
// - unprogrammed device takes commanded address; assigning address zero is ignored
// - invalid bank selection in initialization gets no response
// - bus-fault reply bit is one when the bus test failed
// - otp flag in replies reads one when otp programming is enabled
// - status accepted in standard frames, enhanced frames when enabled
// - status requests ignored while own address is the global zero address
// - status command data bits only feed the frame crc check
// - command code 0001 means status request
// - status request with a different address field is ignored
// - short status reply: 8 to 15 bits, flag byte in low bits, zeros above
// - long status reply: address on top, zeros, flags, crc of 0 to 8 bits
// - error flag reports a detected internal error
// - low-reserve flag set while reservoir node is below threshold
// - self-test flag is one while self-test circuitry is active
// - attribute bits in the reply copy the configured attribute bits
// - switch-state bit reports the bus switch setting, one means closed
// - reply is padded to the response length of the received command
// - switch closes at initialization only if requested and no bus fault
module dsir_responder import dsir_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	input wire logic [2:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire logic i_cmd_valid,
	input wire logic [15:0] i_cmd_word,
	input wire logic i_cmd_long,
	input wire logic i_cmd_enhanced,
	input wire logic i_cmd_crc_ok,
	input wire logic [4:0] i_resp_len,
	input wire logic i_bus_fault,
	input wire logic i_internal_error,
	input wire logic i_reservoir_low,
	input wire logic i_self_test_active,
	output logic o_bus_switch_close,
	output logic o_initialized,
	output logic [3:0] o_assigned_address,
	output logic o_busy,
	output logic o_reply_valid,
	output logic [15:0] o_reply_word,
	output logic [4:0] o_reply_len,
	output logic [7:0] o_reply_crc,
	output logic [3:0] o_reply_crc_len
);
	// bank code check, shared by the init decode and the bank latch guard
	function automatic logic dsir_bank_ok(input logic [1:0] bank);
		dsir_bank_ok = BANK_VALID_MASK[bank];
	endfunction : dsir_bank_ok

	// frame format check for status requests
	function automatic logic dsir_fmt_ok(input logic is_long, input logic is_enh,
		input logic enh_long_en, input logic enh_short_en);
		if (!is_enh) dsir_fmt_ok = 1'b1;
		else if (is_long) dsir_fmt_ok = enh_long_en;
		else dsir_fmt_ok = enh_short_en;
	endfunction : dsir_fmt_ok

	// device state
	dsir_state_t state_reg;
	dsir_state_t state_next;
	logic initialized_reg;
	logic [3:0] assigned_address_reg;
	logic otp_program_enable_reg;
	logic [1:0] bank_reg;
	logic bus_fault_flag_reg;
	logic bus_switch_state_reg;
	// reply staging towards the crc generator
	logic start_reg;
	logic [15:0] word_reg;
	logic [4:0] len_reg;
	logic [3:0] crc_w_reg;
	// reply outputs
	logic reply_valid_reg;
	logic [15:0] reply_word_reg;
	logic [4:0] reply_len_reg;
	logic [7:0] reply_crc_reg;
	logic [3:0] reply_crc_len_reg;

	// software registers
	logic [7:0] ctrl_w;
	logic [7:0] preaddr_w;
	logic [7:0] status_w;
	logic [2:0] event_set_w;

	dsir_reply_if rif ();

	dsir_regs u_regs (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_clk_en(i_clk_en),
		.i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd),
		.i_status(status_w),
		.i_event_set(event_set_w),
		.o_reg_rdata(o_reg_rdata),
		.o_ctrl(ctrl_w),
		.o_preaddr(preaddr_w)
	);

	dsir_crc_gen u_crc (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_clk_en(i_clk_en),
		.rif(rif.crc_side)
	);

	// control fields
	wire logic [1:0] attribute_bits = ctrl_w[CTRL_AT_LSB +: 2];
	wire logic enh_long_en = ctrl_w[CTRL_ENH_LONG_BIT];
	wire logic enh_short_en = ctrl_w[CTRL_ENH_SHORT_BIT];
	wire logic [3:0] crc_len_raw = ctrl_w[CTRL_CRC_LSB +: 4];
	// crc length beyond eight is clamped, the line cannot carry more
	wire logic [3:0] enh_crc_w = (crc_len_raw > CRC_W_MAX) ? CRC_W_MAX : crc_len_raw;
	wire logic [3:0] pre_addr = preaddr_w[3:0];
	wire logic pre_flag = preaddr_w[PRE_FLAG_BIT];

	// command field split; status data bits are never looked at
	wire logic [3:0] cmd_code = i_cmd_word[CMD_LSB +: 4];
	wire logic [3:0] cmd_addr = i_cmd_word[ADDR_LSB +: 4];
	wire logic [3:0] init_pa = i_cmd_word[INIT_PA_LSB +: 4];
	wire logic [1:0] init_bank = i_cmd_word[INIT_BANK_LSB +: 2];
	wire logic init_bs = i_cmd_word[INIT_BS_BIT];
	wire logic init_nv = i_cmd_word[INIT_NV_BIT];

	// own address: preset value or global zero until initialized
	wire logic [3:0] cur_addr = initialized_reg ? assigned_address_reg :
		(pre_flag ? pre_addr : ADDR_GLOBAL);

	// a frame is only decoded when idle and its crc checked good; a bad crc while idle raises an event
	wire logic idle = (state_reg == DSIR_IDLE);
	wire logic frame_seen = i_cmd_valid && idle;
	wire logic frame_take = frame_seen && i_cmd_crc_ok;
	wire logic frame_bad = frame_seen && !i_cmd_crc_ok;

	// initialization decode: standard long frames only
	wire logic is_init = (cmd_code == CMD_INIT) && i_cmd_long && !i_cmd_enhanced;
	wire logic init_pa_ok = (init_pa != ADDR_GLOBAL);
	// preset part must see its own address twice, blank part a zero field
	wire logic init_addr_ok = pre_flag ?
		((init_pa == pre_addr) && (cmd_addr == pre_addr)) :
		(cmd_addr == ADDR_GLOBAL);
	wire logic init_accept = frame_take && is_init && !initialized_reg
		&& dsir_bank_ok(init_bank)
		&& init_pa_ok && init_addr_ok;

	// status decode; nothing but init is recognised before initialization
	wire logic is_status = (cmd_code == CMD_STATUS);
	wire logic status_addr_ok = (cur_addr != ADDR_GLOBAL)
		&& (cmd_addr == cur_addr);
	wire logic status_fmt_ok = dsir_fmt_ok(i_cmd_long, i_cmd_enhanced,
		enh_long_en, enh_short_en);
	wire logic status_accept = frame_take && is_status && initialized_reg
		&& status_addr_ok && status_fmt_ok;

	wire logic reply_go = init_accept || status_accept;
	wire logic frame_ignored = frame_take && !reply_go;

	// switch is closed only when asked for and the downstream test passed
	wire logic init_switch = init_bs && !i_bus_fault;

	// initialization reply word
	wire logic [15:0] init_word = {init_pa, 3'h0, i_bus_fault,
		init_nv, init_switch, init_bank, init_pa};

	// status flag byte shared by the short and long layouts
	wire logic [7:0] status_flags = {
		otp_program_enable_reg,
		i_reservoir_low,
		i_self_test_active,
		bus_switch_state_reg,
		attribute_bits,
		i_internal_error,
		1'b0};
	wire logic [15:0] status_long_word = {cur_addr, 4'h0, status_flags};
	wire logic [15:0] status_short_word = {1'b0, 7'h00, status_flags};

	// short replies take the requested length, stretched to 8 or cut to 15 bits when it lies outside
	wire logic [4:0] short_len = (i_resp_len < SHORT_MIN) ? SHORT_MIN :
		(i_resp_len > SHORT_LEN) ? SHORT_LEN : i_resp_len;
	wire logic [4:0] status_len = i_cmd_long ? LONG_LEN : short_len;
	wire logic [15:0] status_word = i_cmd_long ? status_long_word : status_short_word;
	// standard frames use the four-bit crc, enhanced ones the programmed width
	wire logic [3:0] status_crc_w = i_cmd_enhanced ? enh_crc_w : INIT_CRC_W;

	wire logic [15:0] stage_word = init_accept ? init_word : status_word;
	wire logic [4:0] stage_len = init_accept ? LONG_LEN : status_len;
	wire logic [3:0] stage_crc_w = init_accept ? INIT_CRC_W : status_crc_w;

	// next state: a reply runs through the crc, then we are idle again
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DSIR_IDLE: begin
				if (reply_go) state_next = DSIR_CRC;
			end
			DSIR_CRC: begin
				if (rif.done) state_next = DSIR_IDLE;
			end
			default: state_next = DSIR_IDLE;
		endcase
	end

	// state register and the one-shot crc start
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= DSIR_IDLE;
			start_reg <= 1'b0;
		end else if (i_clk_en) begin
			state_reg <= state_next;
			start_reg <= reply_go;
		end
	end

	// reply staging; held still while the crc walks over it
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			word_reg <= 16'h0000;
			len_reg <= 5'h00;
			crc_w_reg <= 4'h0;
		end else if (i_clk_en && reply_go) begin
			word_reg <= stage_word;
			len_reg <= stage_len;
			crc_w_reg <= stage_crc_w;
		end
	end

	// device state set by an accepted initialization; held afterwards
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			initialized_reg <= 1'b0;
			assigned_address_reg <= 4'h0;
			otp_program_enable_reg <= 1'b0;
			bank_reg <= 2'h0;
			bus_fault_flag_reg <= 1'b0;
			bus_switch_state_reg <= 1'b0;
		end else if (i_clk_en && init_accept) begin
			initialized_reg <= 1'b1;
			assigned_address_reg <= init_pa;
			otp_program_enable_reg <= init_nv;
			bank_reg <= init_bank;
			bus_fault_flag_reg <= i_bus_fault;
			bus_switch_state_reg <= init_switch;
		end
	end

	// reply outputs latch with the crc result, valid for one cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			reply_valid_reg <= 1'b0;
			reply_word_reg <= 16'h0000;
			reply_len_reg <= 5'h00;
			reply_crc_reg <= 8'h00;
			reply_crc_len_reg <= 4'h0;
		end else if (i_clk_en) begin
			reply_valid_reg <= rif.done;
			if (rif.done) begin
				reply_word_reg <= word_reg;
				reply_len_reg <= len_reg;
				reply_crc_reg <= rif.crc;
				reply_crc_len_reg <= crc_w_reg;
			end
		end
	end

	// crc generator hookup
	assign rif.start = start_reg;
	assign rif.word = word_reg;
	assign rif.len = len_reg;
	assign rif.crc_w = crc_w_reg;

	// status byte and event pulses for software
	assign status_w = {otp_program_enable_reg, bus_fault_flag_reg,
		bus_switch_state_reg, initialized_reg, cur_addr};
	assign event_set_w = {frame_bad, frame_ignored, init_accept} & {3{i_clk_en}};

	// pins; bank is kept for the nvm path, shown here only via reply
	assign o_bus_switch_close = bus_switch_state_reg;
	assign o_initialized = initialized_reg;
	assign o_assigned_address = cur_addr;
	assign o_busy = !idle;
	assign o_reply_valid = reply_valid_reg;
	assign o_reply_word = reply_word_reg;
	assign o_reply_len = reply_len_reg;
	assign o_reply_crc = reply_crc_reg;
	assign o_reply_crc_len = reply_crc_len_reg;

	// bank latch kept consistent; a latched code is always a valid one
	wire logic bank_latched_ok = dsir_bank_ok(bank_reg) || !initialized_reg;
	wire logic unused_ok = bank_latched_ok & (|preaddr_w[7:5]) & (|i_cmd_word[7:4]);
endmodule : dsir_responder
`default_nettype wire

// *** test/dsir_responder_assertions.sv ***
// concurrent checks on the status responder top ports
`timescale 1ns/1ns
`default_nettype none
module dsir_responder_assertions (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_bus_fault,
	input wire logic o_bus_switch_close,
	input wire logic o_initialized,
	input wire logic [3:0] o_assigned_address,
	input wire logic o_busy,
	input wire logic o_reply_valid,
	input wire logic [15:0] o_reply_word,
	input wire logic [4:0] o_reply_len,
	input wire logic [7:0] o_reply_crc,
	input wire logic [3:0] o_reply_crc_len
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	property p_pulse;
		o_reply_valid |=> !o_reply_valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reply valid too long");
	// busy covers the crc walk of a short or long reply plus one cycle on each side
	property p_lat;
		$rose(o_busy) |-> ##[10:18] o_reply_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("reply late");
	property p_free;
		o_reply_valid |-> !o_busy;
	endproperty
	a_free: assert property (p_free) else $error("busy at reply");
	property p_len;
		o_reply_valid |-> o_reply_len inside {[5'h08:5'h10]};
	endproperty
	a_len: assert property (p_len) else $error("reply length");
	property p_crcw;
		o_reply_valid |-> o_reply_crc_len <= 4'h8 && (o_reply_crc >> o_reply_crc_len) == 8'h00;
	endproperty
	a_crcw: assert property (p_crcw) else $error("crc width");
	property p_long;
		o_reply_valid && o_reply_len == 5'h10 |->
			o_reply_word[11:9] == 3'h0 && o_reply_word[15:12] == o_assigned_address;
	endproperty
	a_long: assert property (p_long) else $error("long reply head");
	property p_short;
		o_reply_valid && o_reply_len < 5'h10 |-> o_reply_word[15:8] == 8'h00 && !o_reply_word[0];
	endproperty
	a_short: assert property (p_short) else $error("short reply zeros");
	property p_own;
		o_reply_valid |-> o_initialized && o_assigned_address != 4'h0;
	endproperty
	a_own: assert property (p_own) else $error("reply without address");
	property p_keep;
		o_initialized |=> o_initialized && $stable(o_assigned_address);
	endproperty
	a_keep: assert property (p_keep) else $error("address changed");
	property p_echo;
		$rose(o_initialized) |-> ##[0:19] (o_reply_valid && o_reply_word[3:0] == o_assigned_address);
	endproperty
	a_echo: assert property (p_echo) else $error("init reply missing");
	// bus fault is held steady by the bench around each initialization
	property p_switch;
		$rose(o_bus_switch_close) |-> o_initialized && !$past(i_bus_fault);
	endproperty
	a_switch: assert property (p_switch) else $error("switch closed wrongly");
endmodule : dsir_responder_assertions
bind dsir_responder dsir_responder_assertions dsir_responder_assertions_i (
	.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_bus_fault(i_bus_fault),
	.o_bus_switch_close(o_bus_switch_close), .o_initialized(o_initialized),
	.o_assigned_address(o_assigned_address), .o_busy(o_busy), .o_reply_valid(o_reply_valid),
	.o_reply_word(o_reply_word), .o_reply_len(o_reply_len), .o_reply_crc(o_reply_crc),
	.o_reply_crc_len(o_reply_crc_len));
`default_nettype wire

// *** test/dsir_master_model.sv ***
// bus master model presenting received command frames
`timescale 1ns/1ns
`default_nettype none
module dsir_master_model (
	input wire logic i_sys_clk,
	output logic o_cmd_valid,
	output logic [15:0] o_cmd_word,
	output logic o_cmd_long,
	output logic o_cmd_enhanced,
	output logic o_cmd_crc_ok,
	output logic [4:0] o_resp_len
);
	// quiet bus at time zero
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_word = 16'h0000;
		o_cmd_long = 1'b0;
		o_cmd_enhanced = 1'b0;
		o_cmd_crc_ok = 1'b0;
		o_resp_len = 5'h00;
	end
	// one frame; afterwards lines show the inverse so stale values never look valid
	task automatic send(input logic [15:0] w, input logic lng, input logic enh,
		input logic ok, input logic [4:0] rl);
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_word <= w;
		o_cmd_long <= lng;
		o_cmd_enhanced <= enh;
		o_cmd_crc_ok <= ok;
		o_resp_len <= rl;
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b0;
		o_cmd_word <= ~w;
		o_cmd_long <= ~lng;
		o_cmd_enhanced <= ~enh;
		o_cmd_crc_ok <= ~ok;
		o_resp_len <= ~rl;
	endtask : send
endmodule : dsir_master_model
`default_nettype wire

// *** test/test_dsi_init_status_responder.sv ***
// self-checking bench for the initialization and status responder
`timescale 1ns/1ns
`default_nettype none
module test_dsi_init_status_responder;
	import dsir_pkg::*;
	logic clk, rst_b, reg_wr, reg_rd, bus_fault, int_err, res_low, st_act;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rcrc;
	logic cv, cl, ce, cok, sw, inited, busy, rv, clk_en;
	logic [15:0] cw_in, rword;
	logic [4:0] crl, rlen;
	logic [3:0] own, rcw;
	logic m_init, m_nv, m_bs, m_bf;
	logic [3:0] m_own;
	logic [7:0] m_ctrl;
	logic [2:0] m_evt;
	int n_errors, checks_done, cycles, seed;
	dsir_master_model mdl (.i_sys_clk(clk), .o_cmd_valid(cv), .o_cmd_word(cw_in),
		.o_cmd_long(cl), .o_cmd_enhanced(ce), .o_cmd_crc_ok(cok), .o_resp_len(crl));
	dsir_responder dsir_responder_i (.i_sys_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.o_reg_rdata(reg_rdata), .i_cmd_valid(cv), .i_cmd_word(cw_in), .i_cmd_long(cl),
		.i_cmd_enhanced(ce), .i_cmd_crc_ok(cok), .i_resp_len(crl), .i_bus_fault(bus_fault),
		.i_internal_error(int_err), .i_reservoir_low(res_low), .i_self_test_active(st_act),
		.o_bus_switch_close(sw), .o_initialized(inited), .o_assigned_address(own),
		.o_busy(busy), .o_reply_valid(rv), .o_reply_word(rword), .o_reply_len(rlen),
		.o_reply_crc(rcrc), .o_reply_crc_len(rcw));
	// free-running 10 MHz clock
	always #50 clk = ~clk;
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		if (n_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg
	task automatic chk_rpl(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_rpl
	// register bus: one-cycle strobes, read data from the following cycle, held until the next read
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk_reg($sformatf("register %0d", a), e, reg_rdata);
	endtask : rd
	// serial crc, msb first over the sent bits
	function automatic logic [7:0] crc_of(input logic [15:0] w, input logic [4:0] n, input int k);
		logic [7:0] c;
		logic [7:0] p;
		logic [7:0] mk;
		c = (k == 4) ? CRC4_SEED : CRC_GEN_SEED;
		p = (k == 4) ? CRC4_POLY : CRC_GEN_POLY;
		mk = 8'((1 << k) - 1);
		c = c & mk;
		if (k == 0) return 8'h00;
		for (int i = int'(n) - 1; i >= 0; i--) c = ((c << 1) ^ ((w[i] ^ c[k - 1]) ? p : 8'h00)) & mk;
		return c;
	endfunction : crc_of
	// send one frame, predict the answer from the rules, compare
	task automatic frame(input logic [15:0] w, input logic lng, input logic enh, input logic ok,
		input logic [4:0] rl);
		logic ex;
		logic got;
		logic [15:0] ew;
		logic [4:0] el;
		int k;
		mdl.send(w, lng, enh, ok, rl);
		ex = 1'b0;
		ew = 16'h0000;
		el = 5'h10;
		k = 4;
		if (!clk_en) ex = 1'b0;
		else if (!ok) m_evt[2] = 1'b1;
		else if (w[3:0] == CMD_INIT && !m_init && lng && !enh && BANK_VALID_MASK[w[13:12]]
			&& w[11:8] != 4'h0 && w[7:4] == 4'h0) begin
			ex = 1'b1;
			m_init = 1'b1;
			m_own = w[11:8];
			m_nv = w[15];
			m_bf = bus_fault;
			m_bs = w[14] & !bus_fault;
			m_evt[0] = 1'b1;
			ew = {m_own, 3'h0, m_bf, m_nv, m_bs, w[13:12], m_own};
		end else if (w[3:0] == CMD_STATUS && m_init && w[7:4] == m_own
			&& (!enh || m_ctrl[lng ? 2 : 3])) begin
			ex = 1'b1;
			el = lng ? 5'h10 : rl;
			ew = {lng ? m_own : 4'h0, 4'h0, m_nv, res_low, st_act, m_bs, m_ctrl[1:0], int_err, 1'b0};
			k = enh ? ((m_ctrl[7:4] > 4'h8) ? 8 : int'(m_ctrl[7:4])) : 4;
		end else m_evt[1] = 1'b1;
		got = 1'b0;
		for (int n = 0; n < 30 && !got; n++) begin
			@(posedge clk);
			#1 got = (rv === 1'b1);
		end
		chk_rpl("reply present", 16'(ex), 16'(got));
		if (ex && got) begin
			chk_rpl("reply word", ew, rword);
			chk_rpl("reply length", 16'(el), 16'(rlen));
			chk_rpl("reply crc", 16'(crc_of(ew, el, k)), 16'(rcrc));
			chk_rpl("crc length", 16'(k), 16'(rcw));
		end
	endtask : frame
	// two runs: bus test passing, then failing, with a reset between
	initial begin
		logic [31:0] v;
		logic [3:0] pa;
		clk = 1'b0;
		rst_b = 1'b0;
		{reg_wr, reg_rd, bus_fault, int_err, res_low, st_act} = 6'h00;
		clk_en = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		seed = 32'h0b7937b2;
		for (int pass = 0; pass < 2; pass++) begin
			// reset is applied on a clock edge like every other input
			@(posedge clk);
			rst_b <= 1'b0;
			bus_fault <= (pass == 1);
			repeat (20) @(posedge clk);
			rst_b <= 1'b1;
			{m_init, m_nv, m_bs, m_bf, m_own, m_ctrl, m_evt} = '0;
			rd(REG_CTRL, CTRL_RESET);
			rd(REG_PREADDR, PREADDR_RESET);
			rd(3'h5, 8'h00);
			v = $random(seed);
			pa = v[3:0] | 4'h1;
			frame({8'h00, 4'h0, CMD_STATUS}, 1'b1, 1'b0, 1'b1, 5'h10);
			frame({4'h3, pa, 4'h0, CMD_INIT}, 1'b1, 1'b0, 1'b1, 5'h10);
			frame({4'h0, 4'h0, 4'h0, CMD_INIT}, 1'b1, 1'b0, 1'b1, 5'h10);
			frame({4'h0, pa, pa, CMD_INIT}, 1'b1, 1'b0, 1'b1, 5'h10);
			frame({4'h0, pa, 4'h0, CMD_INIT}, 1'b0, 1'b0, 1'b1, 5'h0F);
			frame({v[7:6], (v[5:4] == 2'h3) ? 2'h2 : v[5:4], pa, 4'h0, CMD_INIT}, 1'b1, 1'b0,
				1'b1, 5'h10);
			frame({4'h4, pa ^ 4'h6, 4'h0, CMD_INIT}, 1'b1, 1'b0, 1'b1, 5'h10);
			chk_reg("switch", 8'(m_bs), 8'(sw));
			chk_reg("address", 8'(m_own), 8'(own));
			chk_reg("initialized", 8'(m_init), 8'(inited));
			wr(REG_STATUS, 8'h00);
			rd(REG_STATUS, {m_nv, m_bf, m_bs, m_init, m_own});
			for (int t = 0; t < 24; t++) begin
				v = $random(seed);
				wr(REG_CTRL, v[7:0]);
				m_ctrl = v[7:0];
				int_err <= v[8];
				res_low <= v[9];
				st_act <= v[10];
				frame({8'($random(seed)), v[11] ? m_own : v[15:12],
					(v[19:17] == 3'h0) ? v[23:20] : CMD_STATUS}, v[25], v[26], v[24:22] != 3'h0,
					5'h08 + 5'(v[29:27]));
			end
			// frozen block: a frame and a write while disabled leave no trace
			@(posedge clk);
			clk_en <= 1'b0;
			wr(REG_CTRL, ~m_ctrl);
			frame({8'h00, m_own, CMD_STATUS}, 1'b1, 1'b0, 1'b1, 5'h10);
			@(posedge clk);
			clk_en <= 1'b1;
			rd(REG_CTRL, m_ctrl);
			rd(REG_EVENT, {5'h00, m_evt});
			wr(REG_EVENT, 8'hFF);
			rd(REG_EVENT, 8'h00);
		end
		give_verdict();
	end
endmodule : test_dsi_init_status_responder
`default_nettype wire
